// ### rtl/phy_event_pkg.sv
// Constants for the transceiver event and interrupt block
package phy_event_pkg;
    // Number of monitored event sources
    localparam int SRC_COUNT = 5;
    // Width of the line state field
    localparam int LINE_W = 2;
    // Register indices; byte address is four times the index
    localparam logic [5:0] IDX_RISE_WR = 6'h0D;
    localparam logic [5:0] IDX_RISE_SET = 6'h0E;
    localparam logic [5:0] IDX_RISE_CLR = 6'h0F;
    localparam logic [5:0] IDX_FALL_WR = 6'h10;
    localparam logic [5:0] IDX_FALL_SET = 6'h11;
    localparam logic [5:0] IDX_FALL_CLR = 6'h12;
    localparam logic [5:0] IDX_LIVE_STATUS = 6'h13;
    localparam logic [5:0] IDX_EVENT_LATCH = 6'h14;
    localparam logic [5:0] IDX_LINE_DEBUG = 6'h15;
    localparam logic [5:0] IDX_IRQ_STATUS = 6'h20;
    localparam logic [5:0] IDX_IRQ_MASK = 6'h21;
    localparam logic [5:0] IDX_MODE_CTRL = 6'h22;
    // Source bit positions
    localparam int BIT_HOST_DISC = 0;
    localparam int BIT_BUS_POWER = 1;
    localparam int BIT_SESSION_VALID = 2;
    localparam int BIT_SESSION_END = 3;
    localparam int BIT_ID_GROUND = 4;
    // Host mode flag in the mode control register
    localparam int BIT_HOST_MODE = 0;
    // Reset values
    localparam logic [4:0] EDGE_EN_RESET = 5'h1F;
    localparam logic [4:0] SRC_RESET = 5'h00;
    localparam logic [4:0] IRQ_MASK_RESET = 5'h00;
    localparam logic HOST_MODE_RESET = 1'b0;
    // Byte lanes of the word address that must be zero
    localparam logic [1:0] WORD_ALIGN = 2'h0;
endpackage

// ### rtl/usb_phy_event_interrupt.sv
// Transceiver event detection, edge enables, latch and interrupt logic
`timescale 1ns/1ps

module usb_phy_event_interrupt
    import phy_event_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic core_clk,
    input wire logic rst_b,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Raw comparator and detector levels
    input wire logic hostDisconnect,
    input wire logic busPowerValid,
    input wire logic session_valid_cmp,
    input wire logic session_end_cmp,
    input wire logic id_grounded,
    // Raw line state
    input wire logic [LINE_W-1:0] lineState,
    // Receive-command alert toward the link
    output logic rxCmdAlert,
    // Level interrupt
    output logic irq
);

    // Whole block state
    typedef struct packed {
        logic [4:0] sync1;        // First synchroniser stage
        logic [4:0] sync2;        // Second stage
        logic [4:0] sync3;        // Third stage
        logic [4:0] filt;         // Accepted source levels
        logic [LINE_W-1:0] ls1;   // Line state stages
        logic [LINE_W-1:0] ls2;
        logic [LINE_W-1:0] ls3;
        logic [LINE_W-1:0] lineFilt;
        logic [4:0] riseEn;       // Rising edge enables
        logic [4:0] fallEn;       // Falling edge enables
        logic [4:0] latch;        // Event latch
        logic [4:0] irqStat;      // Sticky interrupt status
        logic [4:0] irqMask;      // Interrupt mask
        logic hostMode;           // Host mode operation
        logic [31:0] rdata;       // Read data captured in setup
        logic rxAlert;            // Alert pulse to link
    } state_type;

    state_type st;
    state_type next_st;

    // Decoded register index and alignment
    logic [5:0] regIdx;
    logic aligned;
    logic setupRead;
    logic accessPhase;
    logic wrAccess;
    logic rdAccess;
    logic [4:0] qualified;
    logic [4:0] riseEv;
    logic [4:0] fallEv;
    logic [4:0] evAll;
    logic [4:0] liveStatus;
    logic [4:0] rdLatchBits;

    // True for any index that the register map holds
    function automatic logic isMapped(input logic [5:0] idx);
        case (idx)
            IDX_RISE_WR, IDX_RISE_SET, IDX_RISE_CLR,
            IDX_FALL_WR, IDX_FALL_SET, IDX_FALL_CLR,
            IDX_LIVE_STATUS, IDX_EVENT_LATCH, IDX_LINE_DEBUG,
            IDX_IRQ_STATUS, IDX_IRQ_MASK, IDX_MODE_CTRL: isMapped = 1'b1;
            default: isMapped = 1'b0;
        endcase
    endfunction

    // Apply a write, set or clear access to a five bit enable field
    function automatic logic [4:0] applyAccess(input logic [4:0] cur,
                                               input logic [5:0] idx,
                                               input logic [5:0] base,
                                               input logic [4:0] data);
        if (idx == base) begin
            applyAccess = data;
        end else if (idx == base + 6'h01) begin
            applyAccess = cur | data;
        end else if (idx == base + 6'h02) begin
            applyAccess = cur & ~data;
        end else begin
            applyAccess = cur;
        end
    endfunction

    // Bus decode
    assign regIdx = paddr[7:2];
    assign aligned = (paddr[1:0] == WORD_ALIGN);
    assign setupRead = psel && !penable && !pwrite;
    assign accessPhase = psel && penable;
    assign wrAccess = accessPhase && pwrite && aligned;
    assign rdAccess = accessPhase && !pwrite && aligned;

    // Edge qualification: a change counts once stages two and three agree
    always_comb begin
        qualified = ~(st.sync2 ^ st.sync3);
        riseEv = qualified & st.sync3 & ~st.filt & st.riseEn;
        fallEv = qualified & ~st.sync3 & st.filt & st.fallEn;
        evAll = riseEv | fallEv;
        // Disconnect only counts in host mode
        evAll[BIT_HOST_DISC] = (riseEv[BIT_HOST_DISC] | fallEv[BIT_HOST_DISC])
            & st.hostMode;
    end

    // Live status with the documented suppression cases
    always_comb begin
        liveStatus = st.filt;
        if (st.riseEn[BIT_BUS_POWER] && st.fallEn[BIT_BUS_POWER]) begin
            liveStatus[BIT_BUS_POWER] = 1'b0;
        end
        if (st.riseEn[BIT_SESSION_END] && st.fallEn[BIT_SESSION_END]) begin
            liveStatus[BIT_SESSION_END] = 1'b0;
        end
    end

    // Latch bits handed out by the current read; only these get cleared
    assign rdLatchBits = (rdAccess && regIdx == IDX_EVENT_LATCH) ? st.rdata[4:0] : 5'h00;

    // Next state
    always_comb begin
        next_st = st;
        // Synchronisers: first stage feeds only the second
        next_st.sync1 = {id_grounded, session_end_cmp, session_valid_cmp,
                         busPowerValid, hostDisconnect};
        next_st.sync2 = st.sync1;
        next_st.sync3 = st.sync2;
        next_st.ls1 = lineState;
        next_st.ls2 = st.ls1;
        next_st.ls3 = st.ls2;
        // Accept agreed levels
        next_st.filt = (qualified & st.sync3) | (~qualified & st.filt);
        if (st.ls2 == st.ls3) begin
            next_st.lineFilt = st.ls3;
        end
        // Latch: new events win over the read clear
        next_st.latch = (st.latch & ~rdLatchBits) | evAll;
        // Sticky interrupt status, write one to clear, set wins
        next_st.irqStat = st.irqStat | evAll;
        if (wrAccess && regIdx == IDX_IRQ_STATUS) begin
            next_st.irqStat = (st.irqStat & ~pwdata[4:0]) | evAll;
        end
        // Alert the link for each cycle with a newly latched event
        next_st.rxAlert = |evAll;
        // Register writes, low five bits only
        // Writes to the read-only indices fall through here and change nothing
        if (wrAccess) begin
            next_st.riseEn = applyAccess(st.riseEn, regIdx, IDX_RISE_WR,
                                         pwdata[4:0]);
            next_st.fallEn = applyAccess(st.fallEn, regIdx, IDX_FALL_WR,
                                         pwdata[4:0]);
            if (regIdx == IDX_IRQ_MASK) begin
                next_st.irqMask = pwdata[4:0];
            end
            if (regIdx == IDX_MODE_CTRL) begin
                next_st.hostMode = pwdata[BIT_HOST_MODE];
            end
        end
        // Read data captured in the setup cycle
        if (setupRead) begin
            next_st.rdata = 32'h0000_0000;
            if (aligned) begin
                unique case (regIdx)
                    IDX_RISE_WR, IDX_RISE_SET, IDX_RISE_CLR: begin
                        next_st.rdata[4:0] = st.riseEn;
                    end
                    IDX_FALL_WR, IDX_FALL_SET, IDX_FALL_CLR: begin
                        next_st.rdata[4:0] = st.fallEn;
                    end
                    IDX_LIVE_STATUS: begin
                        next_st.rdata[4:0] = liveStatus;
                    end
                    IDX_EVENT_LATCH: begin
                        next_st.rdata[4:0] = st.latch;
                    end
                    IDX_LINE_DEBUG: begin
                        next_st.rdata[LINE_W-1:0] = st.lineFilt;
                    end
                    IDX_IRQ_STATUS: begin
                        next_st.rdata[4:0] = st.irqStat;
                    end
                    IDX_IRQ_MASK: begin
                        next_st.rdata[4:0] = st.irqMask;
                    end
                    IDX_MODE_CTRL: begin
                        next_st.rdata[BIT_HOST_MODE] = st.hostMode;
                    end
                    default: begin
                        next_st.rdata = 32'h0000_0000;
                    end
                endcase
            end
        end
    end

    // State register
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            st <= '0;
            st.riseEn <= EDGE_EN_RESET;
            st.fallEn <= EDGE_EN_RESET;
            st.irqMask <= IRQ_MASK_RESET;
            st.hostMode <= HOST_MODE_RESET;
            st.filt <= SRC_RESET;
        end else begin
            st <= next_st;
        end
    end

    // Outputs
    assign prdata = st.rdata;
    assign pready = 1'b1;
    assign pslverr = accessPhase && !(aligned && isMapped(regIdx));
    assign rxCmdAlert = st.rxAlert;
    assign irq = |(st.irqStat & st.irqMask);

    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    // Setup cycle of an aligned read at one register index
    sequence setupOf(logic [5:0] ix);
        setupRead && aligned && regIdx == ix;
    endsequence

    // Latch read in a cycle with no competing event
    sequence latchReadQuiet;
        rdAccess && regIdx == IDX_EVENT_LATCH && evAll == 5'h00;
    endsequence

    // Latch read that meets a fresh event in the same cycle
    sequence latchReadBusy;
        rdAccess && regIdx == IDX_EVENT_LATCH && evAll != 5'h00;
    endsequence

    // Every enabled edge lands in the latch at once, a disconnect edge only in host mode
    chk_latch_sets_edge: assert property (
        (evAll != 5'h00) |=> ((st.latch & $past(evAll)) == $past(evAll)))
        else $error("enabled edge did not set latch");

    // No latch bit appears without an enabled edge behind it
    chk_latch_no_spurious: assert property (
        1'b1 |=> ((st.latch & ~$past(st.latch) & ~$past(evAll)) == 5'h00))
        else $error("latch bit set without enabled edge");

    // A quiet latch read clears every bit it reported
    chk_latch_read_clear: assert property (
        latchReadQuiet |=> ((st.latch & $past(st.rdata[4:0])) == 5'h00))
        else $error("latch read did not clear reported bits");

    // An event that meets a latch read stays latched
    chk_latch_keeps_event: assert property (
        latchReadBusy |=> ((st.latch & $past(evAll)) == $past(evAll)))
        else $error("event lost under latch read");

    // A latch read hands out the latch as it stood
    chk_latch_read_data: assert property (
        setupOf(IDX_EVENT_LATCH) |=> prdata[4:0] == $past(st.latch))
        else $error("latch read data wrong");

    // Outside host mode a clear disconnect latch bit stays clear
    chk_host_gate: assert property (
        (!st.hostMode && !st.latch[BIT_HOST_DISC]) |=> !st.latch[BIT_HOST_DISC])
        else $error("disconnect event outside host mode");

    // Disconnect and ground bits read their accepted levels
    chk_status_levels: assert property (
        setupOf(IDX_LIVE_STATUS) |=>
            (prdata[0] == $past(st.filt[0]) && prdata[4] == $past(st.filt[4])))
        else $error("status levels wrong");

    // Without both enables the bus power bit reads the present level
    chk_status_present: assert property (
        setupOf(IDX_LIVE_STATUS) ##0 !(st.riseEn[1] && st.fallEn[1]) |=>
            prdata[1] == $past(st.filt[1]))
        else $error("bus power status not present level");

    // Both bus power enables set hide the bus power level
    chk_bus_power_mask: assert property (
        setupOf(IDX_LIVE_STATUS) ##0 (st.riseEn[1] && st.fallEn[1]) |=> !prdata[1])
        else $error("bus power status not suppressed");

    // Both session end enables set hide the session end level
    chk_sess_end_mask: assert property (
        setupOf(IDX_LIVE_STATUS) ##0 (st.riseEn[3] && st.fallEn[3]) |=> !prdata[3])
        else $error("session end status not suppressed");

    // Session valid is never hidden by its enables
    chk_sess_valid_live: assert property (
        setupOf(IDX_LIVE_STATUS) |=> prdata[2] == $past(st.filt[2]))
        else $error("session valid status not live");

    // Debug read shows the line state and zeros in bits 7:2 above it
    chk_debug_line: assert property (
        setupOf(IDX_LINE_DEBUG) |=>
            (prdata[7:2] == 6'h00 && prdata[1:0] == $past(st.lineFilt)))
        else $error("debug register wrong");

    // Reserved read bits stay zero on every aligned read
    chk_reserved_zero: assert property (
        rdAccess |-> prdata[31:5] == 27'h0)
        else $error("reserved read bits not zero");

    // Plain write replaces the rising enables
    chk_rise_load_write: assert property (
        wrAccess && regIdx == IDX_RISE_WR |=>
            st.riseEn == $past(pwdata[4:0]))
        else $error("rising enable write access wrong");

    // Set access ors the written ones into the rising enables
    chk_rise_set_write: assert property (
        wrAccess && regIdx == IDX_RISE_SET |=>
            st.riseEn == ($past(st.riseEn) | $past(pwdata[4:0])))
        else $error("rising enable set access wrong");

    // Clear access removes the written ones from the rising enables
    chk_rise_clear_write: assert property (
        wrAccess && regIdx == IDX_RISE_CLR |=>
            st.riseEn == ($past(st.riseEn) & ~$past(pwdata[4:0])))
        else $error("rising enable clear access wrong");

    // Plain write replaces the falling enables
    chk_fall_load_write: assert property (
        wrAccess && regIdx == IDX_FALL_WR |=>
            st.fallEn == $past(pwdata[4:0]))
        else $error("falling enable write access wrong");

    // Set access ors the written ones into the falling enables
    chk_fall_set_write: assert property (
        wrAccess && regIdx == IDX_FALL_SET |=>
            st.fallEn == ($past(st.fallEn) | $past(pwdata[4:0])))
        else $error("falling enable set access wrong");

    // Clear access removes the written ones from the falling enables
    chk_fall_clear_write: assert property (
        wrAccess && regIdx == IDX_FALL_CLR |=>
            st.fallEn == ($past(st.fallEn) & ~$past(pwdata[4:0])))
        else $error("falling enable clear access wrong");

    // Write one clears a sticky status bit unless a new event sets it
    chk_irq_clear: assert property (
        wrAccess && regIdx == IDX_IRQ_STATUS |=>
            (st.irqStat & $past(pwdata[4:0]) & ~$past(evAll)) == 5'h00)
        else $error("sticky status not cleared by write one");

    // Agreeing stages hand their level to the accepted value
    chk_filter_agree: assert property (
        (st.sync2 == st.sync3) |=> st.filt == $past(st.sync3))
        else $error("accepted level did not follow agreed stages");

    // Each event raises the alert for exactly the following cycle
    chk_rx_alert: assert property (
        (evAll != 5'h00) |=> rxCmdAlert ##1 (rxCmdAlert == $past(evAll != 5'h00)))
        else $error("receive command alert missing");

    // No alert follows a cycle without an event
    chk_alert_quiet: assert property (
        (evAll == 5'h00) |=> !rxCmdAlert)
        else $error("alert without an event");

endmodule

// ### tb/usb_link_model.sv
// Link-side model that counts receive-command alerts from the event block
`timescale 1ns/1ps
module usb_link_model (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic rxCmdAlert,
    output int alertCount
);
    // Each high cycle of the alert is one status report the link would fetch
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            alertCount <= 0;
        end else if (rxCmdAlert === 1'b1) begin
            alertCount <= alertCount + 1;
        end
    end
endmodule

// ### tb/tb_usb_phy_event_interrupt.sv
// Self-checking bench for the transceiver event and interrupt block
`timescale 1ns/1ps
module tb_usb_phy_event_interrupt;
    import phy_event_pkg::*;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [4:0] src = 5'h00;  // Source levels, bit order as the status register
    logic [1:0] lineState = 2'h0;
    logic rxCmdAlert;
    logic irq;
    int alertCount;
    int err_count = 0;
    int cmp_count = 0;
    logic [31:0] rdv;
    logic errv;
    int n0;

    // Clock of 40 ns period
    initial begin
        forever #20 core_clk = ~core_clk;
    end

    usb_phy_event_interrupt #(.ADDR_W(8)) i_dut (.core_clk(core_clk), .rst_b(rst_b),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .hostDisconnect(src[0]),
        .busPowerValid(src[1]), .session_valid_cmp(src[2]), .session_end_cmp(src[3]),
        .id_grounded(src[4]), .lineState(lineState), .rxCmdAlert(rxCmdAlert), .irq(irq));

    usb_link_model i_link (.core_clk(core_clk), .rst_b(rst_b), .rxCmdAlert(rxCmdAlert),
        .alertCount(alertCount));

    // Compare one value and count it
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer; entered just after a rising edge, returns just after one
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        // Hold the request until the slave answers; only the watchdog ends a hang
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle edge: the next setup never meets this release in one time step
        @(posedge core_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rdv, exp);
    endtask

    // Let a source change pass the synchroniser and the edge logic
    task automatic settle();
        repeat (8) @(posedge core_clk);
    endtask

    // Enables start at one, every alias reads the same
    task automatic t_reset_values();
        for (int i = 0; i < 6; i++) begin
            rd_chk(8'h34 + 8'(4 * i), 32'h0000_001F);
        end
        rd_chk(8'h4C, 32'h0);
        rd_chk(8'h50, 32'h0);
    endtask

    // Write, set and clear aliases of both enable registers
    task automatic t_enable_access();
        logic [7:0] b;
        for (int k = 0; k < 2; k++) begin
            b = k ? 8'h40 : 8'h34;
            wr(b, 32'hFFFF_FFE5);
            rd_chk(b + 8'h8, 32'h0000_0005);
            wr(b + 8'h4, 32'hFFFF_FF0A);
            rd_chk(b, 32'h0000_000F);
            wr(b + 8'h8, 32'h0000_0003);
            rd_chk(b + 8'h4, 32'h0000_000C);
            wr(b, 32'h0000_001F);
        end
    endtask

    // Live status and its masking by both enables
    task automatic t_live_status();
        src <= 5'h1F;
        settle();
        rd_chk(8'h4C, 32'h0000_0015);
        wr(8'h48, 32'h0000_000A);
        rd_chk(8'h4C, 32'h0000_001F);
        src <= 5'h05;
        settle();
        rd_chk(8'h4C, 32'h0000_0005);
        wr(8'h44, 32'h0000_000A);
        src <= 5'h00;
        settle();
        rd_chk(8'h4C, 32'h0000_0000);
        rd_chk(8'h50, 32'h0000_001E);
    endtask

    // Latch sets on enabled edges only and clears on read
    task automatic t_latch();
        wr(8'h88, 32'h0000_0001);
        src <= 5'h1F;
        settle();
        rd_chk(8'h50, 32'h0000_001F);
        rd_chk(8'h50, 32'h0000_0000);
        wr(8'h34, 32'h0000_000F);
        wr(8'h40, 32'h0000_001B);
        src <= 5'h00;
        settle();
        rd_chk(8'h50, 32'h0000_001B);
        src <= 5'h1F;
        settle();
        rd_chk(8'h50, 32'h0000_000F);
        wr(8'h34, 32'h0000_001F);
        wr(8'h40, 32'h0000_001F);
        wr(8'h88, 32'h0000_0000);
        src <= 5'h1E;
        settle();
        rd_chk(8'h50, 32'h0000_0000);
        src <= 5'h00;
        settle();
        rd_chk(8'h50, 32'h0000_001E);
    endtask

    // Line state debug and refused addresses
    task automatic t_debug_decode();
        for (int i = 0; i < 4; i++) begin
            lineState <= 2'(3 - i);
            settle();
            rd_chk(8'h54, 32'(3 - i));
        end
        rd_chk(8'h60, 32'h0);
        check({31'h0, errv}, 32'h1);
        wr(8'h35, 32'h0000_0000);
        check({31'h0, errv}, 32'h1);
        rd_chk(8'h34, 32'h0000_001F);
    endtask

    // Interrupt raise, clear and mask, with the alert toward the link
    task automatic t_irq();
        wr(8'h80, 32'h0000_001F);
        wr(8'h84, 32'h0000_001F);
        n0 = alertCount;
        src <= 5'h10;
        settle();
        check(32'(alertCount - n0), 32'h1);
        check({31'h0, irq}, 32'h1);
        rd_chk(8'h80, 32'h0000_0010);
        wr(8'h80, 32'h0000_0010);
        check({31'h0, irq}, 32'h0);
        wr(8'h84, 32'h0000_0000);
        src <= 5'h00;
        settle();
        check({31'h0, irq}, 32'h0);
        rd_chk(8'h80, 32'h0000_0010);
        rd_chk(8'h50, 32'h0000_0010);
    endtask

    // Verdict and end of run
    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (6) @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
        t_reset_values();
        t_enable_access();
        t_live_status();
        t_latch();
        t_debug_decode();
        t_irq();
        report_and_stop();
    end

    // Watchdog far beyond the few hundred cycles the tests need
    initial begin
        #(40 * 20000);
        err_count++;
        report_and_stop();
    end
endmodule
